// *** logic/refclk_ctrl.sv ***
// clock-mode and reference-mode controller with apb register access
// assumes an apb master on i_clk; serial clock arrives as an unsynchronised pin
// Overview of operation
// - modes 00/10 internal clock, internal acquisition
// - mode 01 acquisition timed by start pin
// - mode 11 serial clock converts, pin analog
// - ref mode 00 off after scan, 218 wait
// - temperature request wakes reference, waits 244
// - ref mode 01 external single-ended, no internal
// - ref mode 10 default, 218 restart wait
// - ref mode 11 external differential adc reference
// - force bias bit keeps reference on
// - dac powered up with mode 00 keeps on
// - dac pulldown to reference with 00 keeps on
// - always-on reference still waits 188 for temperature
// - clock mode bits 5:4, reference bits 3:2
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module refclk_ctrl (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sclk,
    input wire logic i_convert_start_pin,
    output logic o_convert_start_is_trigger,
    output logic o_internal_conv_clk,
    output logic o_internal_acq,
    output logic o_ref_on,
    output logic o_adc_ref_internal,
    output logic o_adc_ref_differential,
    output logic o_dac_ref_internal,
    output logic o_conv_go,
    output logic o_temp_go
);
    typedef enum logic [2:0] {IDLE, WAKE, SETTLE, CONVERT} phase_e;

    logic [7:0] setup_ff;
    logic [4:0] ctrl_ff;
    refclk_pkg::setup_s cfg;
    refclk_pkg::route_s route;
    phase_e state_ff;
    phase_e nxt_state;
    logic ref_awake_ff;
    logic [1:0] sclk_sync_ff;
    logic sclk_prev_ff;
    logic [1:0] start_sync_ff;
    logic start_prev_ff;
    logic [3:0] div_ff;
    logic int_tick;
    logic ext_tick;
    logic conv_tick;
    logic start_fall;
    logic scan_req;
    logic temp_pending_ff;
    logic always_on;
    logic wc_load;
    logic [8:0] wc_count;
    logic wc_busy;
    logic wc_done;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;

    assign cfg.clock_mode = setup_ff[refclk_pkg::CKM_HI_BIT:refclk_pkg::CKM_LO_BIT];
    assign cfg.reference_mode = setup_ff[refclk_pkg::REFM_HI_BIT:refclk_pkg::REFM_LO_BIT];

    always_comb begin
        route.internal_conv_clk = (cfg.clock_mode != refclk_pkg::CKM_EXT_SCLK);
        route.internal_acq = (cfg.clock_mode == refclk_pkg::CKM_INT_TRIG) ||
                             (cfg.clock_mode == refclk_pkg::CKM_INT_AIN);
        route.start_is_trigger = !cfg.clock_mode[1];
        route.adc_ref_internal = (cfg.reference_mode == refclk_pkg::REFM_INT_BOTH) ||
                                 (cfg.reference_mode == refclk_pkg::REFM_INT_ADC);
        route.adc_ref_differential =
            (cfg.reference_mode == refclk_pkg::REFM_EXT_DIFF);
        route.dac_ref_internal = (cfg.reference_mode == refclk_pkg::REFM_INT_BOTH);
    end

    // apb slave: zero wait states, unmapped address answers slverr
    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign apb_rd = i_psel && !i_penable && !i_pwrite;
    assign addr_ok = (i_paddr == refclk_pkg::ADDR_SETUP) ||
                     (i_paddr == refclk_pkg::ADDR_CTRL) ||
                     (i_paddr == refclk_pkg::ADDR_STATUS);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            setup_ff <= refclk_pkg::SETUP_RESET;
            ctrl_ff <= 5'h00;
        end else begin
            // scan request bit is self-clearing once taken; the temp request bit stays set
            if (state_ff == IDLE && scan_req) begin
                ctrl_ff[refclk_pkg::CTRL_SCAN_BIT] <= 1'b0;
            end
            if (apb_wr && i_paddr == refclk_pkg::ADDR_SETUP) begin
                setup_ff <= i_pwdata[7:0];
            end else if (apb_wr && i_paddr == refclk_pkg::ADDR_CTRL) begin
                ctrl_ff <= i_pwdata[4:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !addr_ok;
            if (apb_rd) begin
                if (i_paddr == refclk_pkg::ADDR_SETUP) begin
                    o_prdata <= {24'h000000, setup_ff};
                end else if (i_paddr == refclk_pkg::ADDR_CTRL) begin
                    o_prdata <= {27'h0, ctrl_ff};
                end else if (i_paddr == refclk_pkg::ADDR_STATUS) begin
                    o_prdata <= {26'h0, ref_awake_ff, wc_busy, 1'b0, state_ff};
                end else begin
                    o_prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // pin synchronisers; first stage is read only by the second
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sclk_sync_ff <= 2'h0;
            sclk_prev_ff <= 1'b0;
            start_sync_ff <= 2'h3;
            start_prev_ff <= 1'b1;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], i_sclk};
            sclk_prev_ff <= sclk_sync_ff[1];
            start_sync_ff <= {start_sync_ff[0], i_convert_start_pin};
            start_prev_ff <= start_sync_ff[1];
        end
    end

    assign ext_tick = sclk_sync_ff[1] && !sclk_prev_ff;
    assign start_fall = !start_sync_ff[1] && start_prev_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            div_ff <= 4'h0;
        end else if (div_ff == refclk_pkg::INT_CLK_DIV - 4'h1) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end

    assign int_tick = (div_ff == refclk_pkg::INT_CLK_DIV - 4'h1);
    assign conv_tick = route.internal_conv_clk ? int_tick : ext_tick;

    // write in modes 1x, falling pin edge in modes 0x
    assign scan_req = route.start_is_trigger ? start_fall : ctrl_ff[refclk_pkg::CTRL_SCAN_BIT];

    assign always_on = ctrl_ff[refclk_pkg::CTRL_FORCE_BIAS_ON_BIT] ||
        (cfg.reference_mode == refclk_pkg::REFM_INT_BOTH &&
         (ctrl_ff[refclk_pkg::CTRL_DACUP_BIT] ||
          ctrl_ff[refclk_pkg::CTRL_DACPD_BIT]));

    always_comb begin
        nxt_state = state_ff;
        wc_load = 1'b0;
        wc_count = 9'h000;
        case (state_ff)
            IDLE: begin
                if (scan_req) begin
                    wc_load = 1'b1;
                    nxt_state = WAKE;
                    if (ctrl_ff[refclk_pkg::CTRL_TEMP_BIT]) begin
                        if (always_on) begin
                            wc_count = refclk_pkg::TEMP_ON_CYC;
                        end else begin
                            wc_count = refclk_pkg::TEMP_WAKE_CYC;
                        end
                    end else if (route.adc_ref_internal && !ref_awake_ff && !always_on) begin
                        wc_count = refclk_pkg::AIN_WAKE_CYC;
                    end else begin
                        wc_load = 1'b0;
                        nxt_state = CONVERT;
                    end
                end
            end
            WAKE: begin
                if (wc_done) begin
                    nxt_state = CONVERT;
                end
            end
            SETTLE: begin
                nxt_state = CONVERT;
            end
            CONVERT: begin
                nxt_state = IDLE;
            end
            default: begin
                nxt_state = IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff <= IDLE;
            temp_pending_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == IDLE && scan_req) begin
                temp_pending_ff <= ctrl_ff[refclk_pkg::CTRL_TEMP_BIT];
            end
        end
    end

    // reference drops after each scan unless an override holds it
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ref_awake_ff <= 1'b0;
        end else if (always_on) begin
            ref_awake_ff <= 1'b1;
        end else if (state_ff == IDLE && nxt_state == WAKE) begin
            ref_awake_ff <= 1'b1;
        end else if (state_ff == IDLE && nxt_state == CONVERT) begin
            ref_awake_ff <= route.adc_ref_internal;
        end else if (state_ff == CONVERT) begin
            ref_awake_ff <= 1'b0;
        end
    end

    wake_counter u_wake (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(wc_load),
        .i_count(wc_count),
        .i_tick(conv_tick),
        .o_busy(wc_busy),
        .o_done(wc_done)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_convert_start_is_trigger <= 1'b1;
            o_internal_conv_clk <= 1'b1;
            o_internal_acq <= 1'b1;
            o_ref_on <= 1'b0;
            o_adc_ref_internal <= 1'b1;
            o_adc_ref_differential <= 1'b0;
            o_dac_ref_internal <= 1'b0;
            o_conv_go <= 1'b0;
            o_temp_go <= 1'b0;
        end else begin
            o_convert_start_is_trigger <= route.start_is_trigger;
            o_internal_conv_clk <= route.internal_conv_clk;
            o_internal_acq <= route.internal_acq;
            o_ref_on <= ref_awake_ff || always_on;
            o_adc_ref_internal <= route.adc_ref_internal;
            o_adc_ref_differential <= route.adc_ref_differential;
            o_dac_ref_internal <= route.dac_ref_internal;
            o_conv_go <= (nxt_state == CONVERT) && (state_ff != CONVERT);
            o_temp_go <= (nxt_state == CONVERT) && (state_ff != CONVERT) &&
                         (state_ff == WAKE ? temp_pending_ff : 1'b0);
        end
    end

    sequence wake_done_s;
        state_ff == WAKE && wc_done;
    endsequence

    sequence scan_end_s;
        state_ff == CONVERT && !always_on;
    endsequence

    wake_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_ff == WAKE && !wc_done) |=> state_ff != CONVERT)
        else $error("conversion started before wake delay");
    wake_go_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wake_done_s |=> o_conv_go)
        else $error("conversion not released after wake delay");
    ref_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        scan_end_s |=> !ref_awake_ff)
        else $error("reference still awake after scan");
    mode11_route_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cfg.clock_mode == refclk_pkg::CKM_EXT_SCLK |=> !o_internal_conv_clk)
        else $error("mode 11 not on external clock");
    mode01_acq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cfg.clock_mode == refclk_pkg::CKM_INT_EXTACQ |=> !o_internal_acq && o_internal_conv_clk)
        else $error("mode 01 routing wrong");
    mode00_trig_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cfg.clock_mode == refclk_pkg::CKM_INT_TRIG |=> o_convert_start_is_trigger)
        else $error("mode 00 pin not trigger");
    force_bias_on_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ctrl_ff[refclk_pkg::CTRL_FORCE_BIAS_ON_BIT] |=> o_ref_on)
        else $error("force bias did not keep reference on");
    dac_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cfg.reference_mode == refclk_pkg::REFM_INT_BOTH &&
         ctrl_ff[refclk_pkg::CTRL_DACUP_BIT]) |=> o_ref_on)
        else $error("dac override lost reference");
    diff_ref_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cfg.reference_mode == refclk_pkg::REFM_EXT_DIFF |=> o_adc_ref_differential)
        else $error("mode 11 reference not differential");
    ext_ref_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cfg.reference_mode == refclk_pkg::REFM_EXT_SE |=> !o_adc_ref_internal)
        else $error("external reference mode used internal");
    temp_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wc_load && ctrl_ff[refclk_pkg::CTRL_TEMP_BIT] && !always_on) |->
        wc_count == refclk_pkg::TEMP_WAKE_CYC)
        else $error("temperature wake count wrong");
    temp_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wc_load && ctrl_ff[refclk_pkg::CTRL_TEMP_BIT] && always_on) |->
        wc_count == refclk_pkg::TEMP_ON_CYC)
        else $error("always-on temperature delay wrong");
endmodule

// *** logic/refclk_pkg.sv ***
// shared constants and carriers for the clock/reference mode controller
// assumes a 125 MHz system clock and an external serial clock sampled as a pin
package refclk_pkg;
    localparam logic [1:0] CKM_INT_TRIG = 2'h0;
    localparam logic [1:0] CKM_INT_EXTACQ = 2'h1;
    localparam logic [1:0] CKM_INT_AIN = 2'h2;
    localparam logic [1:0] CKM_EXT_SCLK = 2'h3;
    localparam logic [1:0] REFM_INT_BOTH = 2'h0;
    localparam logic [1:0] REFM_EXT_SE = 2'h1;
    localparam logic [1:0] REFM_INT_ADC = 2'h2;
    localparam logic [1:0] REFM_EXT_DIFF = 2'h3;
    localparam int CKM_HI_BIT = 5;
    localparam int CKM_LO_BIT = 4;
    localparam int REFM_HI_BIT = 3;
    localparam int REFM_LO_BIT = 2;
    localparam logic [1:0] CKM_RESET = 2'h2;
    localparam logic [1:0] REFM_RESET = 2'h2;
    localparam logic [7:0] SETUP_RESET = 8'h68;
    localparam logic [8:0] AIN_WAKE_CYC = 9'h0da;
    localparam logic [8:0] TEMP_WAKE_CYC = 9'h0f4;
    localparam logic [8:0] TEMP_ON_CYC = 9'h0bc;
    // internal conversion clock divider (system cycles per conversion clock)
    localparam logic [3:0] INT_CLK_DIV = 4'h8;
    // apb register map
    localparam logic [7:0] ADDR_SETUP = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_FORCE_BIAS_ON_BIT = 0;
    localparam int CTRL_SCAN_BIT = 1;
    localparam int CTRL_TEMP_BIT = 2;
    localparam int CTRL_DACUP_BIT = 3;
    localparam int CTRL_DACPD_BIT = 4;

    typedef struct packed {
        logic [1:0] clock_mode;
        logic [1:0] reference_mode;
    } setup_s;

    typedef struct packed {
        logic internal_conv_clk;
        logic internal_acq;
        logic start_is_trigger;
        logic adc_ref_internal;
        logic adc_ref_differential;
        logic dac_ref_internal;
    } route_s;
endpackage

// *** logic/wake_counter.sv ***
// down counter for reference wake-up delays, stepped by conversion clock ticks
// assumes i_tick is a one-cycle enable in the i_clk domain
`timescale 1ns/1ns
module wake_counter (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [8:0] i_count,
    input wire logic i_tick,
    output logic o_busy,
    output logic o_done
);
    logic [8:0] cnt_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_ff <= 9'h000;
            o_done <= 1'b0;
        end else if (i_load) begin
            cnt_ff <= i_count;
            o_done <= 1'b0;
        end else if (i_tick && cnt_ff != 9'h000) begin
            cnt_ff <= cnt_ff - 9'h001;
            o_done <= (cnt_ff == 9'h001);
        end else begin
            o_done <= 1'b0;
        end
    end

    assign o_busy = (cnt_ff != 9'h000);
endmodule

// *** sim/spi_host_model.sv ***
// host side model: serial clock source and convert-start pin driver
// assumes the bench raises i_run only for the length of a frame
`timescale 1ns/1ns
module spi_host_model (
    input wire logic i_run,
    input wire logic i_pulse,
    output logic o_sclk,
    output logic o_convert_start_pin
);
    initial begin
        o_sclk = 1'b0;
        o_convert_start_pin = 1'b1;
    end
    // clock stands low between frames, so no stray ticks reach the counter
    always begin
        wait (i_run);
        #62 o_sclk = 1'b1;
        #63 o_sclk = 1'b0;
    end
    // pulse kept long enough to pass the pin synchroniser
    always @(posedge i_pulse) begin
        o_convert_start_pin = 1'b0;
        #40 o_convert_start_pin = 1'b1;
    end
endmodule

// *** sim/adc_clock_reference_mode_control_test.sv ***
// self-checking bench for the clock/reference mode controller
// assumes apb access to setup and ctrl words; host model drives the pins
`timescale 1ns/1ns
module adc_clock_reference_mode_control_test;
    logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, run, pulse, err, sclk_q;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic o_pready, o_pslverr, host_sclk, host_convert_start_pin, o_trig, o_iclk, o_iacq, o_ref_on;
    logic o_adc_int, o_adc_diff, o_dac_int, o_conv_go, o_temp_go;
    int errors, cmp_count;
    integer seed;

    refclk_ctrl i_refclk_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sclk(host_sclk),
        .i_convert_start_pin(host_convert_start_pin), .o_convert_start_is_trigger(o_trig),
        .o_internal_conv_clk(o_iclk), .o_internal_acq(o_iacq), .o_ref_on(o_ref_on),
        .o_adc_ref_internal(o_adc_int), .o_adc_ref_differential(o_adc_diff),
        .o_dac_ref_internal(o_dac_int), .o_conv_go(o_conv_go), .o_temp_go(o_temp_go));
    spi_host_model i_spi_host_model (.i_run(run), .i_pulse(pulse), .o_sclk(host_sclk),
        .o_convert_start_pin(host_convert_start_pin));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) sclk_q <= host_sclk;

    task report_and_stop;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task check_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask
    task check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task check_count(input string name, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            errors++;
            $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= addr;
        i_pwdata <= wdata;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task set_setup(input logic [1:0] cm, input logic [1:0] rm);
        logic [31:0] r;
        r = $random(seed);
        apb(1'b1, refclk_pkg::ADDR_SETUP, {r[31:8], 2'b01, cm, rm, r[1:0]});
        @(posedge i_clk);
        #1;
        check_bit("trigger", cm[1] == 1'b0, o_trig);
        check_bit("int_clk", cm != refclk_pkg::CKM_EXT_SCLK, o_iclk);
        check_bit("int_acq", cm[0] == 1'b0, o_iacq);
        check_bit("adc_int", rm[0] == 1'b0, o_adc_int);
        check_bit("adc_diff", rm == refclk_pkg::REFM_EXT_DIFF, o_adc_diff);
        check_bit("dac_int", rm == refclk_pkg::REFM_INT_BOTH, o_dac_int);
        apb(1'b0, refclk_pkg::ADDR_SETUP, 32'h0);
        check_word("setup_rd", {28'h0, cm, rm}, {28'h0, rd[5:2]});
    endtask
    // ticks counted in conversion clocks: 8 system cycles, or sclk edges in mode 11
    task run_scan(input logic [31:0] ctrl, input bit pin, input int ticks, input logic tgo,
            input logic ref_after);
        int cyc;
        int edges;
        int lo;
        int hi;
        cyc = 0;
        edges = 0;
        // load lands one edge after the write, or three after the pin falls
        lo = (ticks == 0) ? 2 : ticks * 8 - (pin ? 2 : 4);
        hi = (ticks == 0) ? 2 : lo + 7;
        if (pin) apb(1'b1, refclk_pkg::ADDR_CTRL, ctrl);
        else apb(1'b1, refclk_pkg::ADDR_CTRL, ctrl | 32'h2);
        pulse <= pin;
        run <= (o_iclk === 1'b0);
        while (o_conv_go !== 1'b1 && cyc < 8000) begin
            @(posedge i_clk);
            cyc++;
            if (host_sclk && !sclk_q) edges++;
        end
        check_bit("temp_go", tgo, o_temp_go);
        if (run) check_count("sclk_ticks", ticks, ticks + 1, edges);
        else check_count("conv_cycles", lo, hi, cyc);
        run <= 1'b0;
        pulse <= 1'b0;
        repeat (6) @(posedge i_clk);
        check_bit("ref_on", ref_after, o_ref_on);
    endtask

    initial begin
        seed = 32'h4d86983b;
        {i_rst_n, i_psel, i_penable, i_pwrite, run, pulse} = 6'h0;
        i_paddr = 8'h0;
        i_pwdata = 32'h0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1;
        check_bit("ref_on_rst", 1'b0, o_ref_on);
        apb(1'b0, refclk_pkg::ADDR_SETUP, 32'h0);
        check_word("setup_rst", {24'h0, refclk_pkg::SETUP_RESET}, {24'h0, rd[7:0]});
        apb(1'b1, 8'h0c, 32'hffffffff);
        check_bit("slverr", 1'b1, err);
        apb(1'b0, 8'h0c, 32'h0);
        check_word("unmapped_rd", 32'h0, rd);
        for (int i = 0; i < 16; i++) set_setup(i[3:2], i[1:0]);
        set_setup(2'h2, 2'h2);
        run_scan(32'h0, 1'b0, 218, 1'b0, 1'b0);
        set_setup(2'h2, 2'h0);
        run_scan(32'h0, 1'b0, 218, 1'b0, 1'b0);
        run_scan(32'h4, 1'b0, 244, 1'b1, 1'b0);
        set_setup(2'h2, 2'h1);
        run_scan(32'h0, 1'b0, 0, 1'b0, 1'b0);
        set_setup(2'h2, 2'h3);
        run_scan(32'h0, 1'b0, 0, 1'b0, 1'b0);
        set_setup(2'h2, 2'h2);
        run_scan(32'h8, 1'b0, 218, 1'b0, 1'b0);
        run_scan(32'h1, 1'b0, 0, 1'b0, 1'b1);
        run_scan(32'h5, 1'b0, 188, 1'b1, 1'b1);
        set_setup(2'h2, 2'h0);
        run_scan(32'h8, 1'b0, 0, 1'b0, 1'b1);
        run_scan(32'h10, 1'b0, 0, 1'b0, 1'b1);
        apb(1'b0, refclk_pkg::ADDR_STATUS, 32'h0);
        check_word("status", 32'h0000_0020, rd);
        set_setup(2'h2, 2'h2);
        run_scan(32'h0, 1'b0, 0, 1'b0, 1'b0);
        set_setup(2'h3, 2'h2);
        run_scan(32'h0, 1'b0, 218, 1'b0, 1'b0);
        set_setup(2'h0, 2'h2);
        run_scan(32'h0, 1'b1, 218, 1'b0, 1'b0);
        set_setup(2'h1, 2'h2);
        run_scan(32'h0, 1'b1, 218, 1'b0, 1'b0);
        report_and_stop();
    end

    // watchdog: the full sequence needs roughly 16000 cycles
    initial begin
        repeat (80000) @(posedge i_clk);
        errors++;
        report_and_stop();
    end
endmodule
